// file: logic/inc_skip_and_rotate_exec.sv
`timescale 1ns/1ps
`include "incskip_consts.svh"
module inc_skip_and_rotate_exec
  import incskip_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [11:0] instr,
  input wire logic [7:0] file_rdata,
  output logic [4:0] file_raddr_unused,
  output file_wr_t file_wr,
  output logic [7:0] acc,
  output logic carry,
  output logic skip_next,
  output logic busy_nop
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic is_inc_skip;
  logic is_rot_left;
  logic dest;
  logic [4:0] faddr;
  logic [7:0] inc_res;
  logic [7:0] rot_res;
  logic squash;
  logic exec_ok;

  // the slot after a taken skip carries the squashed word; it must not act
  assign squash = skip_next;
  assign exec_ok = instr_valid && !squash;
  assign is_inc_skip = exec_ok &&
    (instr[`OPC_HI:`OPC_LO] == `OPC_INC_SKIP);
  assign is_rot_left = exec_ok &&
    (instr[`OPC_HI:`OPC_LO] == `OPC_ROT_LEFT);
  assign dest = instr[`DEST_BIT];
  assign faddr = instr[`ADDR_HI:0];
  assign inc_res = file_rdata + `INC_STEP;
  assign rot_res = {file_rdata[`DATA_MSB-1:0], carry};

  // ---------------------------------------------------------------
  // results
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      acc <= `ACC_RESET;
    else if (is_inc_skip && dest == `DEST_ACC)
      acc <= inc_res;
    else if (is_rot_left && dest == `DEST_ACC)
      acc <= rot_res;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      file_wr <= '0;
    else
    begin
      file_wr.en <= (is_inc_skip || is_rot_left) && dest == `DEST_FILE;
      file_wr.addr <= faddr;
      file_wr.data <= is_inc_skip ? inc_res : rot_res;
    end
  end

  // carry only moves on rotate; increment leaves carry alone but sets skip_next and busy_nop on zero
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      carry <= `CARRY_RESET;
    else if (is_rot_left)
      carry <= file_rdata[`DATA_MSB];
  end

  // ---------------------------------------------------------------
  // skip
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      skip_next <= 1'b0;
      busy_nop <= 1'b0;
    end
    else
    begin
      skip_next <= is_inc_skip && inc_res == `RESULT_ZERO;
      busy_nop <= is_inc_skip && inc_res == `RESULT_ZERO;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      file_raddr_unused <= '0;
    else
      file_raddr_unused <= faddr;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // decode rebuilt from the raw word, so a broken decoder is caught
  logic live_word;
  logic [5:0] live_opc;
  logic other_word;

  assign live_word = instr_valid && !skip_next;
  assign live_opc = instr[`OPC_HI:`OPC_LO];
  assign other_word = live_word && live_opc != `OPC_INC_SKIP &&
    live_opc != `OPC_ROT_LEFT;

  a_inc_decode: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    live_word && live_opc == `OPC_INC_SKIP &&
      instr[`DEST_BIT] == `DEST_FILE
    |=> file_wr.en && file_wr.data == $past(file_rdata) + `INC_STEP)
    else $error("increment to file missing");

  a_inc_addr: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    is_inc_skip && dest == `DEST_FILE
    |=> file_wr.addr == $past(instr[`ADDR_HI:0]))
    else $error("increment file address wrong");

  a_other_idle: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    other_word
    |=> !file_wr.en && $stable(acc) && $stable(carry) && !skip_next)
    else $error("foreign opcode had effect");

  a_inc_acc: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    is_inc_skip && dest == `DEST_ACC
    |=> acc == $past(file_rdata) + `INC_STEP && !file_wr.en)
    else $error("increment to accumulator wrong");

  a_inc_flags: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    is_inc_skip |=> $stable(carry))
    else $error("increment touched carry");

  a_inc_keep: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    is_inc_skip && dest == `DEST_FILE |=> $stable(acc))
    else $error("increment to file touched accumulator");

  a_skip_zero: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    is_inc_skip && file_rdata == `WRAP_VALUE
    |=> skip_next ##1 !skip_next)
    else $error("skip not taken on zero");

  a_skip_none: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    is_inc_skip && file_rdata != `WRAP_VALUE |=> !skip_next)
    else $error("skip taken on nonzero");

  a_skip_busy: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    busy_nop == skip_next)
    else $error("no-op cycle flag out of step");

  a_skip_squash: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    skip_next |=> !file_wr.en && $stable(acc) && $stable(carry))
    else $error("squashed slot had effect");

  a_rot_decode: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    live_word && live_opc == `OPC_ROT_LEFT
    |=> carry == $past(file_rdata[`DATA_MSB]))
    else $error("rotate not decoded");

  a_rot_addr: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    is_rot_left && dest == `DEST_FILE
    |=> file_wr.addr == $past(instr[`ADDR_HI:0]))
    else $error("rotate file address wrong");

  a_rot_value: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    is_rot_left && dest == `DEST_ACC
    |=> acc == {$past(file_rdata[`DATA_MSB-1:0]), $past(carry)})
    else $error("rotate value wrong");

  a_rot_nowrite: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    is_rot_left && dest == `DEST_ACC |=> !file_wr.en)
    else $error("rotate to accumulator wrote file");

  a_rot_file: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    is_rot_left && dest == `DEST_FILE |=> file_wr.en && !skip_next)
    else $error("rotate file write wrong");

  a_rot_data: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    is_rot_left && dest == `DEST_FILE
    |=> file_wr.data == {$past(file_rdata[`DATA_MSB-1:0]), $past(carry)}
      && $stable(acc))
    else $error("rotate file data wrong");

  c_skip: cover property (@(posedge clk_sys) disable iff (!resetn)
    is_inc_skip ##1 skip_next);
  c_inc_noskip: cover property (@(posedge clk_sys) disable iff (!resetn)
    is_inc_skip && file_rdata != `WRAP_VALUE);
  c_rot_carry: cover property (@(posedge clk_sys) disable iff (!resetn)
    is_rot_left && file_rdata[`DATA_MSB] && !carry);
  c_rot_file: cover property (@(posedge clk_sys) disable iff (!resetn)
    is_rot_left && dest == `DEST_FILE);
  c_squash_live: cover property (@(posedge clk_sys) disable iff (!resetn)
    skip_next && instr_valid);
endmodule : inc_skip_and_rotate_exec

// file: logic/incskip_consts.svh
`ifndef INCSKIP_CONSTS_SVH
`define INCSKIP_CONSTS_SVH
`define OPC_HI 11
`define OPC_LO 6
`define OPC_INC_SKIP 6'h0F
`define OPC_ROT_LEFT 6'h0D
`define DEST_BIT 5
`define ADDR_HI 4
`define DEST_ACC 1'h0
`define DEST_FILE 1'h1
`define DATA_MSB 7
`define ACC_RESET 8'h00
`define CARRY_RESET 1'h0
`define INC_STEP 8'h01
`define RESULT_ZERO 8'h00
`define WRAP_VALUE 8'hFF
`endif

// file: logic/incskip_pkg.sv
package incskip_pkg;
  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [7:0] data;
  } file_wr_t;
endpackage : incskip_pkg

// file: testbench/file_array_model.sv
`timescale 1ns/1ps
module file_array_model
  import incskip_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [4:0] raddr,
  input wire file_wr_t wr,
  output logic [7:0] rdata
);
  logic [7:0] mem [32];
  // address 0 holds 8'hFF so an increment there wraps to zero
  initial for (int i = 0; i < 32; i++) mem[i] = 8'(8'hFF - i * 7);
  assign rdata = mem[raddr];
  always @(posedge clk_sys)
  begin
    if (wr.en) mem[wr.addr] <= wr.data;
  end
endmodule : file_array_model

// file: testbench/inc_skip_and_rotate_exec_tb.sv
`timescale 1ns/1ps
module inc_skip_and_rotate_exec_tb;
  import incskip_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, instr_valid = 1'b0;
  logic [11:0] instr = 12'h000;
  logic [7:0] file_rdata, acc, e_a = 8'h00, e_v;
  logic carry, skip_next, busy_nop, e_c = 1'b0, e_s = 1'b0, e_en;
  file_wr_t file_wr;
  logic [4:0] raddr_seen;
  logic [11:0] corner [6] = '{12'h3E0, 12'h3E0, 12'h3C0, 12'h345,
    12'h341, 12'h2A3};
  int n_fail = 0, compares = 0, seed = 32'hae95;
  always #4 clk_sys = ~clk_sys;
  inc_skip_and_rotate_exec i_dut (.clk_sys(clk_sys), .resetn(resetn),
    .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata),
    .file_raddr_unused(raddr_seen), .file_wr(file_wr), .acc(acc),
    .carry(carry),
    .skip_next(skip_next), .busy_nop(busy_nop));
  file_array_model i_files (.clk_sys(clk_sys), .raddr(instr[4:0]),
    .wr(file_wr), .rdata(file_rdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // expected result of one word, worked out from the array's read data
  task automatic step(input logic [11:0] w);
    logic take;
    instr = w;
    instr_valid = 1'b1;
    #1 take = !e_s;
    e_en = 1'b0;
    e_s = 1'b0;
    if (take && w[11:6] == 6'h0F)
    begin
      e_v = file_rdata + 8'h01;
      e_s = (e_v == 8'h00);
    end
    if (take && w[11:6] == 6'h0D)
    begin
      e_v = {file_rdata[6:0], e_c};
      e_c = file_rdata[7];
    end
    if (take && (w[11:6] == 6'h0F || w[11:6] == 6'h0D))
    begin
      if (w[5]) e_en = 1'b1;
      else e_a = e_v;
    end
    @(negedge clk_sys);
    check(acc, e_a);
    check(carry, e_c);
    check(file_wr.en, e_en);
    check(skip_next, e_s);
    check(busy_nop, e_s);
    check(raddr_seen, w[4:0]);
    if (e_en) check(file_wr.data, e_v);
    if (e_en) check(file_wr.addr, w[4:0]);
  endtask : step
  initial
  begin
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    // wrap to zero, squashed follower, increment to accumulator, two rotates to accumulator, then a foreign opcode
    foreach (corner[i])
      step(corner[i]);
    repeat (300)
      step({($random(seed) & 1) ? 6'h0F : 6'h0D, 6'($random(seed))});
    repeat (20) step(12'($random(seed)));
    complete_run();
  end
  initial
  begin
    repeat (2000) @(posedge clk_sys);
    n_fail++;
    complete_run();
  end
endmodule : inc_skip_and_rotate_exec_tb
